// ### common/ascs_pkg.sv
package ascs_pkg;
  // storage geometry
  localparam int unsigned NV_WORDS = 64;
  localparam int unsigned AW = 6;
  localparam int unsigned DW = 12;
  localparam int unsigned LOW_WORDS = 14;

  // word locations
  localparam logic [5:0] OFF_MODE = 6'h02;
  localparam logic [5:0] OFF_LOCK = 6'h03;
  localparam logic [5:0] OFF_TRACE = 6'h04;
  localparam logic [5:0] OFF_DIR = 6'h05;
  localparam logic [5:0] OFF_ZERO = 6'h06;
  localparam logic [5:0] OFF_DIAG = 6'h07;
  localparam logic [5:0] OFF_FLUX_HI = 6'h08;
  localparam logic [5:0] OFF_FLUX_LO = 6'h09;
  localparam logic [5:0] OFF_PWM = 6'h0a;
  localparam logic [5:0] OFF_DRV = 6'h0b;
  localparam logic [5:0] OFF_AVG = 6'h0d;
  localparam logic [5:0] OFF_RSV_FIRST = 6'h0e;

  // writable bits of each word
  localparam logic [11:0] MASK_FULL = 12'hfff;
  localparam logic [11:0] MASK_DIR = 12'h007;
  localparam logic [11:0] MASK_FLUX = 12'h0ff;
  localparam logic [11:0] MASK_PWM = 12'h1ff;
  localparam logic [11:0] MASK_DRV = 12'h007;
  localparam logic [11:0] MASK_AVG = 12'h1f8;
  localparam logic [11:0] MASK_NONE = 12'h000;

  // field positions
  localparam int unsigned FREQ_LSB = 0;
  localparam int unsigned POL_LSB = 6;
  localparam int unsigned AVG_LSB = 3;

  // field codes
  localparam logic [2:0] POL_PLUS = 3'h0;
  localparam logic [2:0] POL_MINUS = 3'h7;
  localparam logic [5:0] FREQ_CODE_1K = 6'h00;
  localparam logic [5:0] FREQ_CODE_500 = 6'h07;
  localparam logic [5:0] FREQ_CODE_250 = 6'h3f;
  localparam logic [2:0] DRV_PUSH_PULL = 3'h0;
  localparam logic [2:0] DRV_OPEN_DRAIN = 3'h7;
  localparam logic [5:0] AVG_CODE_TWO = 6'h00;
  localparam logic [5:0] AVG_CODE_EIGHT = 6'h07;
  localparam logic [5:0] AVG_CODE_OFF = 6'h3f;
  localparam logic [2:0] DIR_CCW = 3'h0;
  localparam logic [2:0] DIR_CW = 3'h7;
  localparam logic [11:0] MODE_NORMAL = 12'h000;
  localparam logic [11:0] MODE_USER = 12'h50f;
  localparam logic [11:0] LOCK_KEY = 12'h5a5;

  // reset values
  localparam logic [11:0] RST_WORD = 12'h000;
  localparam logic [11:0] RST_FLUX_HI = 12'h050;
  localparam logic [11:0] RST_FLUX_LO = 12'h005;

  // diagnostic disable bit positions
  localparam int unsigned DIAG_SUPPLY_EXCESS = 11;
  localparam int unsigned DIAG_SUPPLY_RANGE = 10;
  localparam int unsigned DIAG_NV_WRITE_SEQ = 9;
  localparam int unsigned DIAG_AVG_SPREAD = 8;
  localparam int unsigned DIAG_NV_RELOAD_SEQ = 7;
  localparam int unsigned DIAG_PWM_DUTY = 6;
  localparam int unsigned DIAG_FLUX_RANGE = 5;
  localparam int unsigned DIAG_ANALOG_SEQ = 4;
  localparam int unsigned DIAG_CFG_VS_BUF = 3;
  localparam int unsigned DIAG_BUF_VS_NV = 2;
  localparam int unsigned DIAG_TRIPLE_COPY = 1;
  localparam int unsigned DIAG_STARTUP = 0;

  // command operation codes
  localparam logic [2:0] OP_REG_READ = 3'h1;
  localparam logic [2:0] OP_REG_WRITE = 3'h2;
  localparam logic [2:0] OP_NV_READ = 3'h3;
  localparam logic [2:0] OP_NV_WRITE = 3'h4;
  localparam logic [2:0] OP_MODE_CHANGE = 3'h5;

  // pwm timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PWM_HZ_1K = 1000;
  localparam int unsigned PWM_HZ_500 = 500;
  localparam int unsigned PWM_HZ_250 = 250;
  localparam int unsigned PWM_CYC_1K = CLK_HZ / PWM_HZ_1K;
  localparam int unsigned PWM_CYC_500 = CLK_HZ / PWM_HZ_500;
  localparam int unsigned PWM_CYC_250 = CLK_HZ / PWM_HZ_250;
  localparam int unsigned PERIOD_W = 18;

  typedef enum logic [1:0] {
    AVG_SEL_TWO, AVG_SEL_EIGHT, AVG_SEL_OFF, AVG_SEL_UNDEF
  } ascs_avg_t;
endpackage

// ### logic/ascs_nv_array.sv
`timescale 1ns/1ps
module ascs_nv_array (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // masked write
  input wire logic wr_en,
  input wire logic [ascs_pkg::AW-1:0] wr_addr,
  input wire logic [ascs_pkg::DW-1:0] wr_data,
  input wire logic [ascs_pkg::DW-1:0] wr_mask,
  // read
  input wire logic [ascs_pkg::AW-1:0] rd_addr,
  output logic [ascs_pkg::DW-1:0] rd_data,
  output logic [ascs_pkg::LOW_WORDS-1:0][ascs_pkg::DW-1:0] low_words
);
  import ascs_pkg::*;

  logic [DW-1:0] mem_q [NV_WORDS];
  logic [DW-1:0] mem_d [NV_WORDS];

  // stored defaults stand in for the factory image
  function automatic logic [DW-1:0] default_word(input int unsigned idx);
    logic [DW-1:0] w;
    w = RST_WORD;
    if (idx == int'(OFF_FLUX_HI)) w = RST_FLUX_HI;
    if (idx == int'(OFF_FLUX_LO)) w = RST_FLUX_LO;
    return w;
  endfunction

  always_comb begin
    for (int i = 0; i < NV_WORDS; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en) begin
      mem_d[wr_addr] = (mem_q[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NV_WORDS; i++) begin
        mem_q[i] <= default_word(i);
      end
    end else begin
      for (int i = 0; i < NV_WORDS; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign rd_data = mem_q[rd_addr];

  for (genvar g = 0; g < LOW_WORDS; g++) begin : g_low
    assign low_words[g] = mem_q[g];
  end
endmodule // ascs_nv_array

// ### logic/ascs_config_store.sv
`timescale 1ns/1ps
// What this block does
// - polarity code 0x0 gives plus: duty follows the angle upward.
// - polarity minus code 0x7: duty rises as the angle falls.
// - frequency code 0x00 is 1000 Hz, 0x07 500 Hz, 0x3F 250 Hz.
// - driver code 0x0 push-pull, 0x7 open-drain low-side output.
// - averaging code 0x00 two samples, 0x07 eight, 0x3F none.
// - memory is locked only while the stored key equals 0x5A5.
// - the key arrives by a stored-memory write in user mode.
// - stored memory refused in normal mode; 0x0E-0x3F read-only.
// - stored averaging field sits in bits 8..3 of word 0x0D.
// - direction code 0x0 counter-clockwise, 0x7 clockwise.
// - stored settings are what normal mode applies.
// - reported angle is measured from the working zero point, the stored one in normal mode.
// - a set diagnostic bit disables that check; all default active.
// - bits 11..6: supply excess, supply range, write, spread, reload, duty.
// - bits 5..0: flux, analog, cfg/buffer, buffer/store, triple, startup.
// - word 0x04 is a free traceability word with no effect.
// - mode code 0x50F enters user mode, 0x000 normal mode.
module ascs_config_store #(
  parameter int unsigned PWM_PERIOD_1K = ascs_pkg::PWM_CYC_1K,
  parameter int unsigned PWM_PERIOD_500 = ascs_pkg::PWM_CYC_500,
  parameter int unsigned PWM_PERIOD_250 = ascs_pkg::PWM_CYC_250
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command from the serial front end
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [ascs_pkg::AW-1:0] cmd_addr,
  input wire logic [ascs_pkg::DW-1:0] cmd_wdata,
  // answer
  output logic rsp_valid,
  output logic [ascs_pkg::DW-1:0] rsp_rdata,
  output logic rsp_error,
  // angle path
  input wire logic [ascs_pkg::DW-1:0] angle_raw,
  output logic [ascs_pkg::DW-1:0] angle_out,
  output logic [ascs_pkg::DW-1:0] pwm_duty_code,
  // output pin
  input wire logic pwm_level,
  output logic [ascs_pkg::PERIOD_W-1:0] pwm_period_cycles,
  output logic out_pin_o,
  output logic out_pin_oe,
  // applied settings
  output logic user_mode,
  output logic nv_locked,
  output ascs_pkg::ascs_avg_t avg_sel,
  output logic [ascs_pkg::DW-1:0] diag_disable,
  output logic [7:0] flux_upper,
  output logic [7:0] flux_lower
);
  import ascs_pkg::*;

  // writable bits per location; zero means no user write
  function automatic logic [DW-1:0] nv_mask(input logic [AW-1:0] a);
    logic [DW-1:0] m;
    m = MASK_NONE;
    case (a)
      OFF_LOCK, OFF_TRACE, OFF_ZERO, OFF_DIAG: m = MASK_FULL;
      OFF_DIR: m = MASK_DIR;
      OFF_FLUX_HI, OFF_FLUX_LO: m = MASK_FLUX;
      OFF_PWM: m = MASK_PWM;
      OFF_DRV: m = MASK_DRV;
      OFF_AVG: m = MASK_AVG;
      default: m = MASK_NONE;
    endcase
    return m;
  endfunction

  logic [LOW_WORDS-1:0][DW-1:0] nv_low;
  logic [DW-1:0] nv_rd;
  logic nv_wr_en;

  // mode and answer group
  logic [DW-1:0] mode_q, mode_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [DW-1:0] rsp_rdata_q, rsp_rdata_d;
  logic rsp_error_q, rsp_error_d;

  // working configuration group
  logic [DW-1:0] dir_q, dir_d;
  logic [DW-1:0] zero_q, zero_d;
  logic [DW-1:0] diag_q, diag_d;
  logic [DW-1:0] fluxh_q, fluxh_d;
  logic [DW-1:0] fluxl_q, fluxl_d;
  logic [DW-1:0] pwm_q, pwm_d;
  logic [DW-1:0] drv_q, drv_d;
  logic [DW-1:0] avg_q, avg_d;

  // output path group
  logic [DW-1:0] angle_q, angle_d;
  logic [DW-1:0] duty_q, duty_d;
  logic [PERIOD_W-1:0] period_q, period_d;
  logic pin_q, pin_d;
  logic oe_q, oe_d;

  logic is_user;
  logic locked;
  logic [DW-1:0] cmd_mask;
  logic [5:0] freq_code;
  logic [5:0] avg_code;

  // user mode only on the exact code
  assign is_user = (mode_q == MODE_USER);
  assign locked = (nv_low[OFF_LOCK] == LOCK_KEY);
  assign cmd_mask = nv_mask(cmd_addr);

  // write gate: user mode, unlocked, user field
  assign nv_wr_en = cmd_valid && (cmd_op == OP_NV_WRITE) && is_user &&
                    !locked && (cmd_mask != MASK_NONE);

  ascs_nv_array u_nv (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(nv_wr_en),
    .wr_addr(cmd_addr),
    // key and other full-width words stored as received; other fields only within their mask
    .wr_data(cmd_wdata),
    .wr_mask(cmd_mask),
    .rd_addr(cmd_addr),
    .rd_data(nv_rd),
    .low_words(nv_low)
  );

  // working word read back by register reads
  function automatic logic [DW-1:0] cfg_word(input logic [AW-1:0] a,
      input logic [DW-1:0] d5, input logic [DW-1:0] d6,
      input logic [DW-1:0] d7, input logic [DW-1:0] d8,
      input logic [DW-1:0] d9, input logic [DW-1:0] da,
      input logic [DW-1:0] db, input logic [DW-1:0] dd);
    logic [DW-1:0] w;
    w = RST_WORD;
    case (a)
      OFF_DIR: w = d5;
      OFF_ZERO: w = d6;
      OFF_DIAG: w = d7;
      OFF_FLUX_HI: w = d8;
      OFF_FLUX_LO: w = d9;
      OFF_PWM: w = da;
      OFF_DRV: w = db;
      OFF_AVG: w = dd;
      default: w = RST_WORD;
    endcase
    return w;
  endfunction

  always_comb begin
    mode_d = mode_q;
    rsp_valid_d = 1'b0;
    rsp_rdata_d = rsp_rdata_q;
    rsp_error_d = rsp_error_q;
    if (cmd_valid) begin
      rsp_valid_d = 1'b1;
      rsp_rdata_d = RST_WORD;
      rsp_error_d = 1'b0;
      case (cmd_op)
        OP_MODE_CHANGE: mode_d = cmd_wdata;
        OP_NV_READ: begin
          // reserved tail readable in user mode only
          if (is_user && cmd_addr >= OFF_RSV_FIRST) begin
            rsp_rdata_d = nv_rd;
          end else if (is_user && cmd_mask != MASK_NONE) begin
            rsp_rdata_d = nv_rd & cmd_mask;
          end else begin
            rsp_error_d = 1'b1;
          end
        end
        // refusal shows as an error answer
        OP_NV_WRITE: rsp_error_d = !nv_wr_en;
        OP_REG_READ: begin
          if (cmd_addr == OFF_MODE) begin
            rsp_rdata_d = mode_q;
          end else if (cmd_addr == OFF_LOCK || cmd_addr == OFF_TRACE) begin
            rsp_rdata_d = nv_low[cmd_addr[3:0]];
          end else if (cmd_mask != MASK_NONE) begin
            rsp_rdata_d = cfg_word(cmd_addr, dir_q, zero_q, diag_q,
                fluxh_q, fluxl_q, pwm_q, drv_q, avg_q);
          end else begin
            rsp_error_d = 1'b1;
          end
        end
        OP_REG_WRITE: begin
          rsp_error_d = !(is_user && cmd_mask != MASK_NONE &&
                          cmd_addr != OFF_LOCK && cmd_addr != OFF_TRACE);
        end
        default: rsp_error_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_NORMAL;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= RST_WORD;
      rsp_error_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      rsp_error_q <= rsp_error_d;
    end
  end

  always_comb begin
    dir_d = dir_q;
    zero_d = zero_q;
    diag_d = diag_q;
    fluxh_d = fluxh_q;
    fluxl_d = fluxl_q;
    pwm_d = pwm_q;
    drv_d = drv_q;
    avg_d = avg_q;
    if (!is_user) begin
      // normal mode follows the stored image
      dir_d = nv_low[OFF_DIR] & MASK_DIR;
      zero_d = nv_low[OFF_ZERO];
      diag_d = nv_low[OFF_DIAG];
      fluxh_d = nv_low[OFF_FLUX_HI] & MASK_FLUX;
      fluxl_d = nv_low[OFF_FLUX_LO] & MASK_FLUX;
      pwm_d = nv_low[OFF_PWM] & MASK_PWM;
      drv_d = nv_low[OFF_DRV] & MASK_DRV;
      avg_d = nv_low[OFF_AVG] & MASK_AVG;
    end else if (cmd_valid && cmd_op == OP_REG_WRITE) begin
      // trial settings, lost on return to normal mode
      case (cmd_addr)
        OFF_DIR: dir_d = cmd_wdata & MASK_DIR;
        OFF_ZERO: zero_d = cmd_wdata;
        OFF_DIAG: diag_d = cmd_wdata;
        OFF_FLUX_HI: fluxh_d = cmd_wdata & MASK_FLUX;
        OFF_FLUX_LO: fluxl_d = cmd_wdata & MASK_FLUX;
        OFF_PWM: pwm_d = cmd_wdata & MASK_PWM;
        OFF_DRV: drv_d = cmd_wdata & MASK_DRV;
        OFF_AVG: avg_d = cmd_wdata & MASK_AVG;
        default: dir_d = dir_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= RST_WORD;
      zero_q <= RST_WORD;
      // every diagnostic active out of reset
      diag_q <= RST_WORD;
      fluxh_q <= RST_FLUX_HI;
      fluxl_q <= RST_FLUX_LO;
      pwm_q <= RST_WORD;
      drv_q <= RST_WORD;
      avg_q <= RST_WORD;
    end else begin
      dir_q <= dir_d;
      zero_q <= zero_d;
      diag_q <= diag_d;
      fluxh_q <= fluxh_d;
      fluxl_q <= fluxl_d;
      pwm_q <= pwm_d;
      drv_q <= drv_d;
      avg_q <= avg_d;
    end
  end

  assign freq_code = pwm_q[FREQ_LSB +: 6];
  assign avg_code = avg_q[AVG_LSB +: 6];

  always_comb begin
    // offset from zero point, sense set by direction
    if (dir_q[2:0] == DIR_CW) begin
      angle_d = zero_q - angle_raw;
    end else begin
      angle_d = angle_raw - zero_q;
    end
    // minus polarity mirrors the duty code
    if (pwm_q[POL_LSB +: 3] == POL_MINUS) begin
      duty_d = ~angle_q;
    end else begin
      duty_d = angle_q;
    end
    // undefined codes keep the 1000 Hz period
    case (freq_code)
      FREQ_CODE_500: period_d = PERIOD_W'(PWM_PERIOD_500);
      FREQ_CODE_250: period_d = PERIOD_W'(PWM_PERIOD_250);
      default: period_d = PERIOD_W'(PWM_PERIOD_1K);
    endcase
    // open-drain only sinks; high level released
    if (drv_q[2:0] == DRV_OPEN_DRAIN) begin
      pin_d = 1'b0;
      oe_d = !pwm_level;
    end else begin
      pin_d = pwm_level;
      oe_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      angle_q <= RST_WORD;
      duty_q <= RST_WORD;
      period_q <= PERIOD_W'(PWM_PERIOD_1K);
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      angle_q <= angle_d;
      duty_q <= duty_d;
      period_q <= period_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  always_comb begin
    case (avg_code)
      AVG_CODE_TWO: avg_sel = AVG_SEL_TWO;
      AVG_CODE_EIGHT: avg_sel = AVG_SEL_EIGHT;
      AVG_CODE_OFF: avg_sel = AVG_SEL_OFF;
      default: avg_sel = AVG_SEL_UNDEF;
    endcase
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign rsp_error = rsp_error_q;
  assign angle_out = angle_q;
  assign pwm_duty_code = duty_q;
  assign pwm_period_cycles = period_q;
  assign out_pin_o = pin_q;
  assign out_pin_oe = oe_q;
  assign user_mode = is_user;
  assign nv_locked = locked;
  // bit n disables check n, see DIAG_* positions
  assign diag_disable = diag_q;
  assign flux_upper = fluxh_q[7:0];
  assign flux_lower = fluxl_q[7:0];
endmodule // ascs_config_store

// ### verif/ascs_config_store_assertions.sv
`timescale 1ns/1ps
module ascs_config_store_assertions #(
  parameter int unsigned PWM_PERIOD_1K = 50000,
  parameter int unsigned PWM_PERIOD_500 = 100000,
  parameter int unsigned PWM_PERIOD_250 = 200000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command and answer
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [ascs_pkg::AW-1:0] cmd_addr,
  input wire logic [ascs_pkg::DW-1:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  // outputs watched
  input wire logic [ascs_pkg::DW-1:0] angle_out,
  input wire logic [ascs_pkg::DW-1:0] pwm_duty_code,
  input wire logic pwm_level,
  input wire logic [ascs_pkg::PERIOD_W-1:0] pwm_period_cycles,
  input wire logic out_pin_o,
  input wire logic out_pin_oe,
  input wire logic user_mode,
  input wire logic nv_locked
);
  import ascs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_take(logic [2:0] o);
    cmd_valid && cmd_op == o;
  endsequence
  sequence s_nv_wr;
    s_take(OP_NV_WRITE);
  endsequence
  a_answer_next: assert property (
    cmd_valid |=> rsp_valid) else $error("command not answered");
  a_no_idle_answer: assert property (
    !cmd_valid |=> !rsp_valid) else $error("answer without command");
  a_nv_normal_refused: assert property (
    s_nv_wr ##0 !user_mode |=> rsp_error) else $error("nv write in normal");
  a_reserved_read_only: assert property (
    s_nv_wr ##0 cmd_addr >= OFF_RSV_FIRST |=> rsp_error)
    else $error("reserved word written");
  a_locked_refused: assert property (
    s_nv_wr ##0 nv_locked |=> rsp_error && $stable(nv_locked))
    else $error("write accepted while locked");
  a_key_locks: assert property (
    s_nv_wr ##0 (cmd_addr == OFF_LOCK && cmd_wdata == LOCK_KEY && user_mode
    && !nv_locked) |=> nv_locked) else $error("key did not lock");
  a_user_enter: assert property (
    s_take(OP_MODE_CHANGE) ##0 cmd_wdata == MODE_USER |=> user_mode)
    else $error("user mode not entered");
  a_user_leave: assert property (
    s_take(OP_MODE_CHANGE) ##0 cmd_wdata != MODE_USER |=> !user_mode)
    else $error("user mode not left");
  a_mode_holds: assert property (
    !(cmd_valid && cmd_op == OP_MODE_CHANGE) |=> $stable(user_mode))
    else $error("mode changed by itself");
  a_duty_follows: assert property (
    $past(rst_n) |-> pwm_duty_code == $past(angle_out) ||
    pwm_duty_code == ~$past(angle_out)) else $error("duty not from angle");
  a_pin_drive: assert property (
    $past(rst_n) |-> (out_pin_o == $past(pwm_level) && out_pin_oe) ||
    (!out_pin_o && out_pin_oe == !$past(pwm_level)))
    else $error("pin drive wrong");
  a_period_legal: assert property (
    pwm_period_cycles inside {PWM_PERIOD_1K, PWM_PERIOD_500, PWM_PERIOD_250})
    else $error("period not a legal value");
endmodule // ascs_config_store_assertions

bind ascs_config_store ascs_config_store_assertions #(
  .PWM_PERIOD_1K(PWM_PERIOD_1K),
  .PWM_PERIOD_500(PWM_PERIOD_500),
  .PWM_PERIOD_250(PWM_PERIOD_250)
) u_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .cmd_valid(cmd_valid),
  .cmd_op(cmd_op),
  .cmd_addr(cmd_addr),
  .cmd_wdata(cmd_wdata),
  .rsp_valid(rsp_valid),
  .rsp_error(rsp_error),
  .angle_out(angle_out),
  .pwm_duty_code(pwm_duty_code),
  .pwm_level(pwm_level),
  .pwm_period_cycles(pwm_period_cycles),
  .out_pin_o(out_pin_o),
  .out_pin_oe(out_pin_oe),
  .user_mode(user_mode),
  .nv_locked(nv_locked)
);

// ### verif/ascs_host_model.sv
`timescale 1ns/1ps
module ascs_host_model (
  // clock
  input wire logic clk_sys,
  // command out
  output logic cmd_valid,
  output logic [2:0] cmd_op,
  output logic [ascs_pkg::AW-1:0] cmd_addr,
  output logic [ascs_pkg::DW-1:0] cmd_wdata,
  // answer in
  input wire logic rsp_valid,
  input wire logic [ascs_pkg::DW-1:0] rsp_rdata,
  input wire logic rsp_error
);
  import ascs_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 6'h00;
    cmd_wdata = 12'h000;
  end
  task automatic xfer(input logic [2:0] o, input logic [AW-1:0] a,
      input logic [DW-1:0] d, output logic [DW-1:0] q, output logic e);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    // released lines must not look like a held request
    cmd_addr <= ~a;
    cmd_wdata <= ~d;
    @(negedge clk_sys);
    q = (rsp_valid === 1'b1) ? rsp_rdata : 'x;
    e = (rsp_valid === 1'b1) ? rsp_error : 1'bx;
  endtask
endmodule // ascs_host_model

// ### verif/ascs_config_store_test.sv
`timescale 1ns/1ps
module ascs_config_store_test;
  import ascs_pkg::*;
  localparam int unsigned P1 = 50;
  localparam int unsigned P2 = 100;
  localparam int unsigned P3 = 200;
  logic clk_sys;
  logic rst_n;
  logic cmd_valid;
  logic [2:0] cmd_op;
  logic [AW-1:0] cmd_addr;
  logic [DW-1:0] cmd_wdata;
  logic rsp_valid;
  logic [DW-1:0] rsp_rdata;
  logic rsp_error;
  logic [DW-1:0] angle_raw;
  logic [DW-1:0] angle_out;
  logic [DW-1:0] pwm_duty_code;
  logic pwm_level;
  logic [PERIOD_W-1:0] pwm_period_cycles;
  logic out_pin_o;
  logic out_pin_oe;
  logic user_mode;
  logic nv_locked;
  ascs_avg_t avg_sel;
  logic [DW-1:0] diag_disable;
  logic [7:0] flux_upper;
  logic [7:0] flux_lower;
  logic [DW-1:0] rd;
  logic er;
  int fail_count = 0;
  int compares = 0;
  ascs_config_store #(.PWM_PERIOD_1K(P1), .PWM_PERIOD_500(P2),
      .PWM_PERIOD_250(P3)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_error(rsp_error), .angle_raw(angle_raw), .angle_out(angle_out),
    .pwm_duty_code(pwm_duty_code), .pwm_level(pwm_level),
    .pwm_period_cycles(pwm_period_cycles), .out_pin_o(out_pin_o),
    .out_pin_oe(out_pin_oe), .user_mode(user_mode), .nv_locked(nv_locked),
    .avg_sel(avg_sel), .diag_disable(diag_disable),
    .flux_upper(flux_upper), .flux_lower(flux_lower));
  ascs_host_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [17:0] exp,
      input logic [17:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [2:0] o, input logic [AW-1:0] a,
      input logic [DW-1:0] d);
    u_host.xfer(o, a, d, rd, er);
  endtask
  task automatic t_reset();
    cmd(OP_REG_READ, OFF_MODE, 12'h000);
    chk("mode word", 18'h0, 18'(rd));
    cmd(OP_NV_READ, OFF_TRACE, 12'h000);
    chk("nv read normal", 18'h1, 18'(er));
    cmd(OP_NV_WRITE, OFF_TRACE, 12'h123);
    chk("nv write normal", 18'h1, 18'(er));
    chk("period", 18'(P1), 18'(pwm_period_cycles));
    chk("diag", 18'h0, 18'(diag_disable));
    chk("flux limits", 18'h5005, 18'({flux_upper, flux_lower}));
    $display("test reset done");
  endtask
  task automatic t_user();
    cmd(OP_MODE_CHANGE, OFF_MODE, MODE_USER);
    chk("user mode", 18'h1, 18'(user_mode));
    cmd(OP_NV_READ, OFF_LOCK, 12'h000);
    chk("key default", 18'h0, 18'(rd));
    cmd(OP_NV_WRITE, OFF_RSV_FIRST, 12'h111);
    chk("reserved write", 18'h1, 18'(er));
    cmd(OP_NV_READ, 6'h3f, 12'h000);
    chk("reserved read", 18'h0, 18'(er));
    cmd(OP_NV_WRITE, OFF_TRACE, 12'ha5c);
    cmd(OP_NV_READ, OFF_TRACE, 12'h000);
    chk("trace word", 18'ha5c, 18'(rd));
    cmd(OP_NV_WRITE, OFF_AVG, 12'hfff);
    cmd(OP_NV_READ, OFF_AVG, 12'h000);
    chk("avg word", 18'h1f8, 18'(rd));
    cmd(OP_REG_WRITE, OFF_AVG, 12'h008);
    chk("avg undefined", 18'h3, 18'(avg_sel));
    $display("test user done");
  endtask
  task automatic t_apply();
    logic [5:0] fq;
    logic [5:0] av;
    logic m;
    logic lev;
    logic [DW-1:0] ang;
    logic [DW-1:0] dg;
    logic [DW-1:0] dty;
    for (int i = 0; i < 3; i++) begin
      fq = (i == 0) ? FREQ_CODE_1K : (i == 1) ? FREQ_CODE_500 : FREQ_CODE_250;
      av = (i == 0) ? AVG_CODE_TWO : (i == 1) ? AVG_CODE_EIGHT : AVG_CODE_OFF;
      m = (i == 1);
      lev = (i != 0);
      dg = 12'h001 << (i == 0 ? DIAG_STARTUP : i == 1 ? DIAG_ANALOG_SEQ :
          DIAG_AVG_SPREAD);
      @(posedge clk_sys);
      pwm_level <= lev;
      cmd(OP_MODE_CHANGE, OFF_MODE, MODE_USER);
      cmd(OP_NV_WRITE, OFF_PWM, {3'h0, m ? POL_MINUS : POL_PLUS, fq});
      cmd(OP_NV_WRITE, OFF_DRV, {9'h0, m ? DRV_OPEN_DRAIN : DRV_PUSH_PULL});
      cmd(OP_NV_WRITE, OFF_DIR, {9'h0, m ? DIR_CW : DIR_CCW});
      cmd(OP_NV_WRITE, OFF_ZERO, 12'h100);
      cmd(OP_NV_WRITE, OFF_AVG, {3'h0, av, 3'h0});
      cmd(OP_NV_WRITE, OFF_DIAG, dg);
      cmd(OP_REG_WRITE, OFF_ZERO, 12'hfff);
      cmd(OP_MODE_CHANGE, OFF_MODE, MODE_NORMAL);
      // reload, then angle, then duty
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      ang = m ? 12'h100 - angle_raw : angle_raw - 12'h100;
      // invert at twelve bits before widening
      dty = m ? ~ang : ang;
      chk("angle", 18'(ang), 18'(angle_out));
      chk("duty", 18'(dty), 18'(pwm_duty_code));
      chk("period", 18'(i == 0 ? P1 : i == 1 ? P2 : P3),
          18'(pwm_period_cycles));
      chk("pin", 18'(m ? {1'b0, !lev} : {lev, 1'b1}),
          18'({out_pin_o, out_pin_oe}));
      chk("avg", 18'(i), 18'(avg_sel));
      chk("diag", 18'(dg), 18'(diag_disable));
    end
    $display("test apply done");
  endtask
  task automatic t_lock();
    cmd(OP_MODE_CHANGE, OFF_MODE, MODE_USER);
    cmd(OP_NV_WRITE, OFF_LOCK, 12'h5a4);
    chk("near key", 18'h0, 18'(nv_locked));
    cmd(OP_NV_WRITE, OFF_LOCK, LOCK_KEY);
    chk("locked", 18'h1, 18'(nv_locked));
    cmd(OP_NV_WRITE, OFF_TRACE, 12'h777);
    chk("locked write", 18'h1, 18'(er));
    cmd(OP_NV_READ, OFF_TRACE, 12'h000);
    chk("trace kept", 18'ha5c, 18'(rd));
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("unlocked", 18'h0, 18'(nv_locked));
    $display("test lock done");
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    angle_raw = 12'h345;
    pwm_level = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_user();
    t_apply();
    t_lock();
    test_done();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    test_done();
  end
endmodule // ascs_config_store_test
